//--- saec_serial_audio.sv
`timescale 1ns/1ps
`include "saec_consts.svh"

module saec_serial_audio
    import saec_pkg::*;
#(
    parameter int WORD_W = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // serial link, partner drives clock and frame sync
    input wire logic link_sck,
    input wire logic link_fs,
    input wire logic link_sdi,
    output logic link_sdo,
    // events
    output logic irq,
    output logic error_event
);

    localparam int CW = $clog2(WORD_W + 1);
    localparam logic [CW-1:0] WCNT = CW'(WORD_W);
    localparam logic [CW-1:0] LAST = CW'(WORD_W - 1);

    // ****************************************************
    // decode helpers
    // ****************************************************
    function automatic logic is_mapped(input logic [7:0] ofs);
        is_mapped = (ofs == `SAEC_OFS_AUDIO_CTRL) || (ofs == `SAEC_OFS_MODULE_CTRL) ||
            (ofs == `SAEC_OFS_STATUS) || (ofs == `SAEC_OFS_INT_CLEAR) ||
            (ofs == `SAEC_OFS_INT_ENABLE) || (ofs == `SAEC_OFS_RX_DATA) ||
            (ofs == `SAEC_OFS_TX_BUF);
    endfunction : is_mapped

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_mask

    function automatic logic [31:0] sext(input logic [WORD_W-1:0] w, input logic en);
        sext = {{(32 - WORD_W){en & w[WORD_W-1]}}, w};
    endfunction : sext

    // ****************************************************
    // state
    // ****************************************************
    logic [31:0] ctrl_reg;
    logic on_reg;
    logic [3:0] flag_reg;
    logic [3:0] int_en_reg;
    logic halted_reg;
    logic rx_valid_reg;
    logic [WORD_W-1:0] rx_hold_reg;
    logic [WORD_W-1:0] tx_buf_reg;
    logic tx_full_reg;
    logic [WORD_W-1:0] tx_last_reg;
    logic [WORD_W-1:0] tx_sh_reg;
    logic [WORD_W-1:0] rx_sh_reg;
    logic [CW-1:0] rx_cnt_reg;
    logic rx_skip_reg;
    logic fs_prev_reg;
    logic sck_s1, sck_s2, sck_s3;
    logic fs_s1, fs_s2;
    logic sdi_s1, sdi_s2;
    logic aw_rdy_reg, w_rdy_reg, ar_rdy_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg, rvalid_reg, sdo_reg, irq_reg, err_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;

    // ****************************************************
    // effective settings
    // ****************************************************
    logic aud_en, mono_eff, is_pcm, is_i2s, run;
    saec_fmt_t fmt_eff;
    assign aud_en = ctrl_reg[`SAEC_B_AUD_EN];
    // plain operation falls back to pulse framing
    assign fmt_eff = aud_en ? saec_fmt_t'(ctrl_reg[`SAEC_B_FMT_HI:`SAEC_B_FMT_LO]) : SAEC_FMT_PCM;
    assign mono_eff = aud_en & ctrl_reg[`SAEC_B_MONO];
    assign is_pcm = (fmt_eff == SAEC_FMT_PCM);
    assign is_i2s = (fmt_eff == SAEC_FMT_I2S);
    assign run = on_reg & ~halted_reg;

    // ****************************************************
    // link input synchronisers
    // ****************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {sck_s1, sck_s2, sck_s3} <= `SAEC_SCK_SYNC_IDLE; // link clock idles high, no false edge
            {fs_s1, fs_s2, sdi_s1, sdi_s2} <= 4'h0;
        end else begin
            sck_s1 <= link_sck;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            fs_s1 <= link_fs;
            fs_s2 <= fs_s1;
            sdi_s1 <= link_sdi;
            sdi_s2 <= sdi_s1;
        end
    end

    // ****************************************************
    // link events
    // ****************************************************
    logic rise, fall, bound, take_tx, ev_frm, ev_rov, ev_tur, rx_done, pop;
    logic [WORD_W-1:0] rx_word, tx_word;
    logic [3:0] ev;
    assign rise = sck_s2 & ~sck_s3;
    assign fall = ~sck_s2 & sck_s3;
    // pcm frames start on the pulse edge, channel formats on either edge
    assign bound = fall & run & (is_pcm ? (fs_s2 & ~fs_prev_reg) : (fs_s2 != fs_prev_reg));
    // mono reuses the left word for the right channel
    assign take_tx = bound & (~mono_eff | is_pcm | ~fs_s2);
    assign tx_word = (bound & ~take_tx) ? tx_last_reg : (tx_full_reg ? tx_buf_reg : '0);
    assign ev_tur = take_tx & ~tx_full_reg;
    assign ev_frm = bound & (rx_cnt_reg != '0) & (rx_cnt_reg != WCNT);
    assign rx_done = rise & run & ~rx_skip_reg & (rx_cnt_reg == LAST);
    assign rx_word = {rx_sh_reg[WORD_W-2:0], sdi_s2};
    assign pop = arvalid & ar_rdy_reg & (araddr == `SAEC_OFS_RX_DATA);
    assign ev_rov = rx_done & rx_valid_reg & ~pop;
    assign ev = {rx_done, ev_tur, ev_rov, ev_frm};

    // ****************************************************
    // receive shifter
    // ****************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_cnt_reg <= WCNT;
            rx_skip_reg <= 1'b0;
            rx_sh_reg <= '0;
        end else if (bound) begin
            rx_cnt_reg <= '0;
            rx_skip_reg <= is_i2s;
        end else if (rise & run) begin
            if (rx_skip_reg) begin
                rx_skip_reg <= 1'b0;
            end else if (rx_cnt_reg != WCNT) begin
                rx_sh_reg <= rx_word;
                rx_cnt_reg <= rx_cnt_reg + 1'b1;
            end
        end
    end

    // holding word; an ignored overflow keeps the old word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_valid_reg <= 1'b0;
            rx_hold_reg <= '0;
        end else if (rx_done & (~rx_valid_reg | pop)) begin
            rx_valid_reg <= 1'b1;
            rx_hold_reg <= rx_word;
        end else if (pop) begin
            rx_valid_reg <= 1'b0;
        end
    end

    // ****************************************************
    // transmit shifter, changes on falling link edges
    // ****************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_sh_reg <= '0;
            tx_last_reg <= '0;
            sdo_reg <= 1'b0;
            fs_prev_reg <= 1'b0;
        end else if (fall) begin
            fs_prev_reg <= fs_s2;
            if (!run) begin
                sdo_reg <= 1'b0;
            end else if (bound) begin
                if (take_tx) begin
                    tx_last_reg <= tx_word;
                end
                // i2s puts the msb one clock after the edge
                if (is_i2s) begin
                    tx_sh_reg <= tx_word;
                    sdo_reg <= 1'b0;
                end else begin
                    tx_sh_reg <= {tx_word[WORD_W-2:0], 1'b0};
                    sdo_reg <= tx_word[WORD_W-1];
                end
            end else begin
                sdo_reg <= tx_sh_reg[WORD_W-1];
                tx_sh_reg <= {tx_sh_reg[WORD_W-2:0], 1'b0};
            end
        end
    end

    // ****************************************************
    // axi write path
    // ****************************************************
    logic do_wr;
    logic [31:0] wmask, ctrl_allow;
    assign do_wr = ~aw_rdy_reg & ~w_rdy_reg & ~bvalid_reg;
    assign wmask = strb_mask(w_strb_reg);
    // audio fields frozen while the module runs
    assign ctrl_allow = `SAEC_CTRL_MASK & ~(on_reg ? `SAEC_CTRL_OFF_ONLY : 32'h00000000);

    // address and data taken independently
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_rdy_reg <= 1'b1;
            w_rdy_reg <= 1'b1;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `SAEC_RESP_OKAY;
        end else begin
            if (awvalid & aw_rdy_reg) begin
                aw_rdy_reg <= 1'b0;
                aw_addr_reg <= awaddr;
            end
            if (wvalid & w_rdy_reg) begin
                w_rdy_reg <= 1'b0;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end
            if (do_wr) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= is_mapped(aw_addr_reg) ? `SAEC_RESP_OKAY : `SAEC_RESP_SLVERR;
            end
            if (bvalid_reg & bready) begin
                bvalid_reg <= 1'b0;
                aw_rdy_reg <= 1'b1;
                w_rdy_reg <= 1'b1;
            end
        end
    end

    // control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `SAEC_CTRL_RESET;
            on_reg <= 1'b0;
            int_en_reg <= 4'h0;
        end else if (do_wr) begin
            if (aw_addr_reg == `SAEC_OFS_AUDIO_CTRL) begin
                ctrl_reg <= (ctrl_reg & ~(wmask & ctrl_allow)) | (w_data_reg & wmask & ctrl_allow);
            end
            if (aw_addr_reg == `SAEC_OFS_MODULE_CTRL && w_strb_reg[0]) begin
                on_reg <= w_data_reg[`SAEC_B_ON];
            end
            if (aw_addr_reg == `SAEC_OFS_INT_ENABLE && w_strb_reg[0]) begin
                int_en_reg <= w_data_reg[`SAEC_NUM_EV-1:0];
            end
        end
    end

    // transmit buffer; a write in the consume cycle keeps it full
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_buf_reg <= '0;
            tx_full_reg <= 1'b0;
        end else if (do_wr && aw_addr_reg == `SAEC_OFS_TX_BUF) begin
            tx_buf_reg <= w_data_reg[WORD_W-1:0];
            tx_full_reg <= 1'b1;
        end else if (take_tx) begin
            tx_full_reg <= 1'b0;
        end
    end

    // ****************************************************
    // halt, flags and event outputs
    // ****************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            halted_reg <= 1'b0;
        end else if (!on_reg) begin
            halted_reg <= 1'b0;
        end else if ((ev_rov & ~ctrl_reg[`SAEC_B_IGN_ROV]) | (ev_tur & ~ctrl_reg[`SAEC_B_IGN_TUR])) begin
            halted_reg <= 1'b1;
        end
    end

    // sticky flags, a new event beats a clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < `SAEC_NUM_EV; gi++) begin : g_flag
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    flag_reg[gi] <= 1'b0;
                end else if (ev[gi]) begin
                    flag_reg[gi] <= 1'b1;
                end else if (do_wr && aw_addr_reg == `SAEC_OFS_INT_CLEAR && w_data_reg[gi]) begin
                    flag_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // error event and interrupt level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            err_reg <= (flag_reg[`SAEC_EV_FRM] & ctrl_reg[`SAEC_B_FRM_EN]) |
                (flag_reg[`SAEC_EV_ROV] & ctrl_reg[`SAEC_B_ROV_EN]) |
                (flag_reg[`SAEC_EV_TUR] & ctrl_reg[`SAEC_B_TUR_EN]);
            irq_reg <= |(flag_reg & int_en_reg);
        end
    end

    // ****************************************************
    // axi read path
    // ****************************************************
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h00000000;
        case (araddr)
            `SAEC_OFS_AUDIO_CTRL: rd_val = ctrl_reg & `SAEC_CTRL_MASK;
            `SAEC_OFS_MODULE_CTRL: rd_val[`SAEC_B_ON] = on_reg;
            `SAEC_OFS_STATUS: begin
                rd_val[`SAEC_NUM_EV-1:0] = flag_reg;
                rd_val[`SAEC_B_HALTED] = halted_reg;
                rd_val[`SAEC_B_RX_VALID] = rx_valid_reg;
                rd_val[`SAEC_B_TX_FULL] = tx_full_reg;
            end
            `SAEC_OFS_INT_ENABLE: rd_val[`SAEC_NUM_EV-1:0] = int_en_reg;
            `SAEC_OFS_RX_DATA: rd_val = sext(rx_hold_reg, ctrl_reg[`SAEC_B_SIGN_EXT]);
            default: rd_val = 32'h00000000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_rdy_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `SAEC_RESP_OKAY;
        end else if (arvalid & ar_rdy_reg) begin
            ar_rdy_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_val;
            rresp_reg <= is_mapped(araddr) ? `SAEC_RESP_OKAY : `SAEC_RESP_SLVERR;
        end else if (rvalid_reg & rready) begin
            rvalid_reg <= 1'b0;
            ar_rdy_reg <= 1'b1;
        end
    end

    assign awready = aw_rdy_reg;
    assign wready = w_rdy_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = ar_rdy_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign link_sdo = sdo_reg;
    assign irq = irq_reg;
    assign error_event = err_reg;

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_ctrl_read;
        arvalid && arready && araddr == `SAEC_OFS_AUDIO_CTRL;
    endsequence
    property p_resv_zero;
        s_ctrl_read |=> rvalid && (rdata & ~`SAEC_CTRL_MASK) == 32'h0 && rdata == $past(ctrl_reg);
    endproperty
    a_resv_zero: assert property (p_resv_zero) else $error("reserved bits not zero");

    property p_sign_ext;
        (pop && ctrl_reg[`SAEC_B_SIGN_EXT] && rx_hold_reg[WORD_W-1]) |=>
            rdata[31] && rdata[WORD_W-1:0] == $past(rx_hold_reg);
    endproperty
    a_sign_ext: assert property (p_sign_ext) else $error("rx word not sign extended");

    property p_frm_event;
        (flag_reg[`SAEC_EV_FRM] && ctrl_reg[`SAEC_B_FRM_EN]) |=> error_event;
    endproperty
    a_frm_event: assert property (p_frm_event) else $error("frame error event missing");

    property p_rov_event;
        ev_rov ##1 ctrl_reg[`SAEC_B_ROV_EN] |=> error_event;
    endproperty
    a_rov_event: assert property (p_rov_event) else $error("overflow event missing");

    property p_no_event;
        (flag_reg[2:0] & {ctrl_reg[`SAEC_B_TUR_EN], ctrl_reg[`SAEC_B_ROV_EN], ctrl_reg[`SAEC_B_FRM_EN]}) == 3'h0
            |=> !error_event;
    endproperty
    a_no_event: assert property (p_no_event) else $error("ungated error event");

    property p_rov_ignore;
        (ev_rov && ctrl_reg[`SAEC_B_IGN_ROV] && !halted_reg) |=> !halted_reg && rx_hold_reg == $past(rx_hold_reg);
    endproperty
    a_rov_ignore: assert property (p_rov_ignore) else $error("ignored overflow disturbed data");

    property p_tur_halt;
        (ev_tur && !ctrl_reg[`SAEC_B_IGN_TUR] && on_reg) |=> halted_reg ##1 halted_reg || !on_reg;
    endproperty
    a_tur_halt: assert property (p_tur_halt) else $error("critical underrun did not halt");

    property p_frozen;
        (do_wr && on_reg && aw_addr_reg == `SAEC_OFS_AUDIO_CTRL) |=> ctrl_reg[7:0] == $past(ctrl_reg[7:0]);
    endproperty
    a_frozen: assert property (p_frozen) else $error("audio field written while on");

    property p_mono_gate;
        !aud_en |-> fmt_eff == SAEC_FMT_PCM && !mono_eff;
    endproperty
    a_mono_gate: assert property (p_mono_gate) else $error("audio settings act while disabled");

endmodule : saec_serial_audio

//--- saec_consts.svh
`ifndef SAEC_CONSTS_SVH
`define SAEC_CONSTS_SVH

// ****************************************************
// register byte offsets
// ****************************************************
`define SAEC_OFS_AUDIO_CTRL 8'h00
`define SAEC_OFS_MODULE_CTRL 8'h04
`define SAEC_OFS_STATUS 8'h08
`define SAEC_OFS_INT_CLEAR 8'h0C
`define SAEC_OFS_INT_ENABLE 8'h10
`define SAEC_OFS_RX_DATA 8'h14
`define SAEC_OFS_TX_BUF 8'h18

// ****************************************************
// serial_audio_control fields
// ****************************************************
`define SAEC_B_SIGN_EXT 15
`define SAEC_B_FRM_EN 12
`define SAEC_B_ROV_EN 11
`define SAEC_B_TUR_EN 10
`define SAEC_B_IGN_ROV 9
`define SAEC_B_IGN_TUR 8
`define SAEC_B_AUD_EN 7
`define SAEC_B_MONO 3
`define SAEC_B_FMT_HI 1
`define SAEC_B_FMT_LO 0
`define SAEC_CTRL_MASK 32'h00009F8B
`define SAEC_CTRL_OFF_ONLY 32'h0000008B
`define SAEC_CTRL_RESET 32'h00000000
`define SAEC_SCK_SYNC_IDLE 3'h7

// ****************************************************
// module control, status and interrupt fields
// ****************************************************
`define SAEC_B_ON 0
`define SAEC_NUM_EV 4
`define SAEC_EV_FRM 0
`define SAEC_EV_ROV 1
`define SAEC_EV_TUR 2
`define SAEC_EV_RXRDY 3
`define SAEC_B_HALTED 4
`define SAEC_B_RX_VALID 5
`define SAEC_B_TX_FULL 6
`define SAEC_RESP_OKAY 2'h0
`define SAEC_RESP_SLVERR 2'h2

`endif

//--- saec_pkg.sv
package saec_pkg;

    // framing formats as coded in audio_format_select
    typedef enum logic [1:0] {
        SAEC_FMT_I2S = 2'b00,
        SAEC_FMT_LJ = 2'b01,
        SAEC_FMT_RJ = 2'b10,
        SAEC_FMT_PCM = 2'b11
    } saec_fmt_t;

endpackage : saec_pkg

//--- saec_link_partner.sv
`timescale 1ns/1ps

// ****************************************************
// serial partner: drives clock, frame sync and data in
// ****************************************************
module saec_link_partner (
    // lines driven by the partner
    output logic link_sck,
    output logic link_fs,
    output logic link_sdi,
    // line driven by the block
    input wire logic link_sdo
);
    // clock stands high between frames, no free running
    initial begin
        link_sck = 1'b1;
        link_fs = 1'b0;
        link_sdi = 1'b1;
    end

    // one word, msb first; nbits below 16 cuts the word short
    task automatic xfer(input logic [15:0] w, input int nbits, input logic pulse, input logic lvl,
                        output logic [15:0] got);
        got = '0;
        for (int i = 0; i < nbits; i++) begin
            link_sck = 1'b0;
            link_fs = pulse ? (i == 0) : lvl;
            link_sdi = w[15-i];
            #62.5;
            link_sck = 1'b1;
            got = {got[14:0], link_sdo};
            #62.5;
        end
        // released data line must not keep its last value
        link_sdi = ~link_sdi;
    endtask : xfer
endmodule : saec_link_partner

//--- saec_serial_audio_tb.sv
`timescale 1ns/1ps
`include "saec_consts.svh"

module saec_serial_audio_tb import saec_pkg::*;;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, link_sck, link_fs, link_sdi, link_sdo, irq, error_event;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_v;
    logic [1:0] bresp, rresp, rs;
    logic [15:0] got;
    int n_fail, samples_checked;

    // ****************************************************
    // block, partner, clock and watchdog
    // ****************************************************
    saec_serial_audio #(.WORD_W(16)) i_saec_serial_audio (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .link_sck(link_sck), .link_fs(link_fs), .link_sdi(link_sdi),
        .link_sdo(link_sdo), .irq(irq), .error_event(error_event));
    saec_link_partner i_saec_link_partner (.link_sck(link_sck), .link_fs(link_fs),
        .link_sdi(link_sdi), .link_sdo(link_sdo));

    // 200 MHz system clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // all frames together take well under this span
    initial begin
        #300us;
        n_fail++;
        summarize();
    end

    // write: address and data offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ad, wd;
        ad = 0;
        wd = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                ad = 1;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wd = 1;
            end
        end while (!(ad && wd));
        do @(posedge aclk); while (!bvalid);
        rs = bresp;
    endtask : axw

    // read: bready and rready stay high for the whole run
    task automatic axr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!(arvalid && arready));
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rd_v = rdata;
        rs = rresp;
    endtask : axr

    task automatic chk(input string nm, input logic [31:0] got_v, input logic [31:0] exp_v);
        samples_checked++;
        if (got_v !== exp_v) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp_v, got_v);
        end
    endtask : chk

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        axr(a);
        chk(nm, rd_v & m, e);
    endtask : rdchk

    // frame then settle: link lines pass a two stage synchroniser
    task automatic frame(input logic [15:0] w, input int n, input logic p, input logic l);
        // keep link edges off the system clock edges
        #1;
        i_saec_link_partner.xfer(w, n, p, l, got);
        repeat (8) @(posedge aclk);
    endtask : frame

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    // ****************************************************
    // scenarios
    // ****************************************************
    task automatic t_regs();
        rdchk("ctrl reset", 8'h00, 32'hFFFFFFFF, 32'h0);
        chk("event reset", {irq, error_event}, 32'h0);
        axw(8'h00, 32'hFFFFFFFF);
        chk("bresp", rs, 32'h0);
        rdchk("ctrl unimpl", 8'h00, 32'hFFFFFFFF, 32'h00009F8B);
        for (int f = 0; f < 4; f++) begin
            axw(8'h00, f);
            rdchk("format", 8'h00, 32'hFFFFFFFF, f);
        end
        axr(8'h1C);
        chk("unmapped", {rs, rd_v[29:0]}, 32'h80000000);
        $display("test regs done");
    endtask : t_regs

    task automatic t_lock();
        axw(8'h00, 32'h8B);
        axw(8'h04, 32'h1);
        axw(8'h00, 32'h0);
        rdchk("locked", 8'h00, 32'hFFFFFFFF, 32'h8B);
        axw(8'h00, 32'h9F00);
        rdchk("free bits", 8'h00, 32'hFFFFFFFF, 32'h9F8B);
        axw(8'h04, 32'h0);
        axw(8'h00, 32'h0);
        rdchk("unlocked", 8'h00, 32'hFFFFFFFF, 32'h0);
        $display("test lock done");
    endtask : t_lock

    task automatic t_rx();
        axw(8'h00, 32'h8100);
        axw(8'h04, 32'h1);
        frame(16'h8001, 16, 1'b1, 1'b0);
        chk("zero fill tx", got, 32'h0);
        rdchk("sign ext", 8'h14, 32'hFFFFFFFF, 32'hFFFF8001);
        axw(8'h00, 32'h0100);
        frame(16'h8001, 16, 1'b1, 1'b0);
        rdchk("no sign ext", 8'h14, 32'hFFFFFFFF, 32'h00008001);
        rdchk("underrun soft", 8'h08, 32'h17, 32'h4);
        $display("test rx done");
    endtask : t_rx

    task automatic t_err();
        // event outputs follow a register write by one more cycle
        axw(8'h00, 32'h0500);
        @(posedge aclk);
        chk("tur event", error_event, 32'h1);
        axw(8'h00, 32'h0100);
        @(posedge aclk);
        chk("tur gated", error_event, 32'h0);
        axw(8'h10, 32'h4);
        @(posedge aclk);
        chk("irq on", irq, 32'h1);
        axw(8'h10, 32'h0);
        @(posedge aclk);
        chk("irq masked", irq, 32'h0);
        axw(8'h0C, 32'h7);
        rdchk("cleared", 8'h08, 32'h7, 32'h0);
        axw(8'h00, 32'h0B00);
        frame(16'h1111, 16, 1'b1, 1'b0);
        frame(16'h2222, 16, 1'b1, 1'b0);
        chk("rov event", error_event, 32'h1);
        rdchk("rov kept", 8'h14, 32'hFFFFFFFF, 32'h1111);
        rdchk("rov soft", 8'h08, 32'h12, 32'h2);
        axw(8'h00, 32'h0100);
        axw(8'h0C, 32'h7);
        frame(16'h3333, 16, 1'b1, 1'b0);
        frame(16'h4444, 16, 1'b1, 1'b0);
        chk("rov gated", error_event, 32'h0);
        rdchk("rov halts", 8'h08, 32'h12, 32'h12);
        axw(8'h04, 32'h0);
        axr(8'h14);
        axw(8'h00, 32'h0);
        axw(8'h0C, 32'h7);
        axw(8'h04, 32'h1);
        frame(16'h0, 16, 1'b1, 1'b0);
        rdchk("tur halts", 8'h08, 32'h14, 32'h14);
        axw(8'h04, 32'h0);
        axw(8'h00, 32'h1300);
        axw(8'h0C, 32'h7);
        axw(8'h04, 32'h1);
        frame(16'h5555, 8, 1'b1, 1'b0);
        frame(16'h6666, 16, 1'b1, 1'b0);
        rdchk("frame err", 8'h08, 32'h1, 32'h1);
        chk("frm event", error_event, 32'h1);
        $display("test errors done");
    endtask : t_err

    task automatic t_mono();
        axw(8'h04, 32'h0);
        axw(8'h00, 32'h0389);
        axw(8'h0C, 32'h7);
        axw(8'h04, 32'h1);
        frame(16'h0, 16, 1'b0, 1'b1);
        axw(8'h18, 32'hA5C3);
        frame(16'h0, 16, 1'b0, 1'b0);
        chk("left", got, 32'hA5C3);
        frame(16'h0, 16, 1'b0, 1'b1);
        chk("right repeat", got, 32'hA5C3);
        // i2s stereo: msb leaves one link clock after the word select edge
        axw(8'h04, 32'h0);
        axw(8'h00, 32'h0380);
        axw(8'h04, 32'h1);
        axw(8'h18, 32'hA5C3);
        rdchk("tx full", 8'h08, 32'h40, 32'h40);
        frame(16'h0, 16, 1'b0, 1'b0);
        chk("i2s late msb", got, 32'h52E1);
        $display("test mono and i2s done");
    endtask : t_mono

    // reset for four cycles, then the scenarios in turn
    initial begin
        n_fail = 0;
        samples_checked = 0;
        aresetn = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        bready = 1'b1;
        rready = 1'b1;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_lock();
        t_rx();
        t_err();
        t_mono();
        summarize();
    end
endmodule : saec_serial_audio_tb
